/* File: rtl/occ_checker.sv */
// One clock verification timer: flags a fault when the watched clock stops toggling.
`timescale 1ns/1ns
`include "occ_map.svh"
module occ_checker
	import occ_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic check_on,
	input wire logic fault_clear,
	input wire logic watched_clk,
	output logic fault,
	output occ_chk_state_type state
);
	logic edge_seen;
	logic [`OCC_CNT_W-1:0] cnt_q;
	occ_chk_state_type state_q;
	occ_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.en(en),
		.async_in(watched_clk),
		.edge_seen(edge_seen)
	);
	// The system clock is the independent reference; the watched clock must
	// toggle at least once in every timeout window.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= OCC_CHK_IDLE;
			cnt_q <= '0;
		end else if (en) begin
			case (state_q)
				OCC_CHK_IDLE: begin
					cnt_q <= '0;
					if (check_on) begin
						state_q <= OCC_CHK_RUN;
					end
				end
				OCC_CHK_RUN: begin
					if (!check_on) begin
						state_q <= OCC_CHK_IDLE;
					end else if (edge_seen) begin
						cnt_q <= '0;
					end else if (cnt_q == `OCC_CNT_W'(`OCC_CHECK_TIMEOUT_CYC - 1)) begin
						state_q <= OCC_CHK_FAIL;
					end else begin
						cnt_q <= cnt_q + `OCC_CNT_W'(1);
					end
				end
				OCC_CHK_FAIL: begin
					cnt_q <= '0;
					if (fault_clear || !check_on) begin
						state_q <= OCC_CHK_IDLE;
					end
				end
				default: begin
					state_q <= OCC_CHK_IDLE;
				end
			endcase
		end
	end
	assign fault = (state_q == OCC_CHK_FAIL);
	assign state = state_q;
endmodule

/* File: rtl/occ_map.svh */
// Register offsets, field positions, reset values and timing counts of the clock check block.
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
`define OCC_ADDR_W 8
`define OCC_OFF_RUN_CFG 8'h60
`define OCC_OFF_FAULT_STATUS 8'h70
`define OCC_OFF_FAULT_MASK 8'h74
`define OCC_OFF_CHECK_STATE 8'h78
`define OCC_POS_PLL_PD 13
`define OCC_POS_PLL_OE_N 12
`define OCC_POS_PLL_CHK 10
`define OCC_POS_CRYSTAL_CODE_HI 9
`define OCC_POS_CRYSTAL_CODE_LO 6
`define OCC_POS_SRC_HI 5
`define OCC_POS_SRC_LO 4
`define OCC_POS_BOSC_CHK 3
`define OCC_POS_MOSC_CHK 2
`define OCC_RST_CRYSTAL_CODE 4'hb
`define OCC_RST_SRC 2'h0
`define OCC_RST_PLL_PD 1'h1
`define OCC_RST_PLL_OE_N 1'h1
`define OCC_RST_HI_ONES 8'hff
`define OCC_POS_HI_ONES_LO 14
`define OCC_CRYSTAL_CODE_FIRST_VALID 4'h4
`define OCC_CHECK_TIMEOUT_NS 10000
`define OCC_CLK_PERIOD_NS 40
`define OCC_CHECK_TIMEOUT_CYC (`OCC_CHECK_TIMEOUT_NS / `OCC_CLK_PERIOD_NS)
`define OCC_CNT_W 12
`endif

/* File: rtl/occ_pkg.sv */
// Types shared by the clock check block.
package occ_pkg;
	typedef enum logic [1:0] {
		OCC_SRC_MAIN = 2'b00,
		OCC_SRC_BOOT = 2'b01,
		OCC_SRC_BOOT_DIV4 = 2'b10,
		OCC_SRC_RSVD = 2'b11
	} occ_src_type;
	typedef enum logic [1:0] {
		OCC_PLL_NORMAL = 2'b00,
		OCC_PLL_OUT_OFF = 2'b01,
		OCC_PLL_POWER_DOWN = 2'b10
	} occ_pll_mode_type;
	typedef enum logic [1:0] {
		OCC_CHK_IDLE = 2'b00,
		OCC_CHK_RUN = 2'b01,
		OCC_CHK_FAIL = 2'b10
	} occ_chk_state_type;
endpackage

/* File: rtl/occ_sync.sv */
// Two-stage synchroniser followed by an edge detector.
`timescale 1ns/1ns
module occ_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic async_in,
	output logic edge_seen
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else if (en) begin
			meta_q <= async_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	assign edge_seen = sync_q ^ last_q;
endmodule

/* File: rtl/occ_top.sv */
// Run clock configuration register low part, PLL mode control and clock verification.
//
// Functional notes
// - PLL check enable bit 10 runs PLL timer.
// - Crystal code bits 9:6, reset 0xb.
// - Codes 0-3 reserved; 4-9 low crystal frequencies.
// - Codes 10-15 higher frequencies; 11 is 6 MHz.
// - Source select bits 5:4 picks oscillator leg.
// - Boot oscillator check enable bit 3.
// - Main oscillator check enable bit 2.
// - Bits 1:0 reserved, read-only, write ignored.
// - Power-down wins; both clear means normal.
`timescale 1ns/1ns
`include "occ_map.svh"
module occ_top
	import occ_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [`OCC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic pll_clk_in,
	input wire logic boot_osc_in,
	input wire logic main_osc_in,
	output logic [3:0] crystal_code,
	output occ_src_type osc_leg_source_select,
	output logic pll_power_down,
	output logic pll_output_enable_n,
	output occ_pll_mode_type pll_mode,
	output logic irq
);
	logic pll_check_enable_q;
	logic boot_osc_check_enable_q;
	logic main_osc_check_enable_q;
	logic [3:0] crystal_code_q;
	occ_src_type src_q;
	logic pll_pd_q;
	logic pll_oe_n_q;
	occ_pll_mode_type pll_mode_q;
	logic [2:0] status_q;
	logic [2:0] mask_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic [31:0] cfg_view;
	logic [2:0] fault_now;
	logic [2:0] fault_last_q;
	logic [2:0] fault_rise;
	logic [2:0] check_on;
	occ_chk_state_type chk_state [3];
	logic wr_cfg;
	logic rd_status;

	assign wr_cfg = reg_wr && (reg_addr == `OCC_OFF_RUN_CFG);
	assign rd_status = reg_rd && (reg_addr == `OCC_OFF_FAULT_STATUS);
	assign check_on = {pll_check_enable_q, boot_osc_check_enable_q, main_osc_check_enable_q};

	// Configuration fields; reserved bits 1:0 are never stored.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_check_enable_q <= 1'b0;
			crystal_code_q <= `OCC_RST_CRYSTAL_CODE;
			src_q <= occ_src_type'(`OCC_RST_SRC);
			boot_osc_check_enable_q <= 1'b0;
			main_osc_check_enable_q <= 1'b0;
			pll_pd_q <= `OCC_RST_PLL_PD;
			pll_oe_n_q <= `OCC_RST_PLL_OE_N;
		end else if (clk_en && wr_cfg) begin
			pll_check_enable_q <= reg_wdata[`OCC_POS_PLL_CHK];
			// A reserved crystal code is refused so the PLL setting never
			// references an undefined frequency.
			if (reg_wdata[`OCC_POS_CRYSTAL_CODE_HI:`OCC_POS_CRYSTAL_CODE_LO] >= `OCC_CRYSTAL_CODE_FIRST_VALID) begin
				crystal_code_q <= reg_wdata[`OCC_POS_CRYSTAL_CODE_HI:`OCC_POS_CRYSTAL_CODE_LO];
			end
			// The reserved source code is refused and the old source kept.
			if (reg_wdata[`OCC_POS_SRC_HI:`OCC_POS_SRC_LO] != OCC_SRC_RSVD) begin
				src_q <= occ_src_type'(reg_wdata[`OCC_POS_SRC_HI:`OCC_POS_SRC_LO]);
			end
			boot_osc_check_enable_q <= reg_wdata[`OCC_POS_BOSC_CHK];
			main_osc_check_enable_q <= reg_wdata[`OCC_POS_MOSC_CHK];
			pll_pd_q <= reg_wdata[`OCC_POS_PLL_PD];
			pll_oe_n_q <= reg_wdata[`OCC_POS_PLL_OE_N];
		end
	end

	// PLL mode follows the stored controls with one register stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_mode_q <= OCC_PLL_POWER_DOWN;
		end else if (clk_en) begin
			if (pll_pd_q) begin
				pll_mode_q <= OCC_PLL_POWER_DOWN;
			end else if (!pll_oe_n_q) begin
				pll_mode_q <= OCC_PLL_NORMAL;
			end else begin
				pll_mode_q <= OCC_PLL_OUT_OFF;
			end
		end
	end

	// Index 2 is the PLL, 1 the boot oscillator, 0 the main oscillator.
	occ_checker u_chk_main (
		.clk(clk),
		.rst_b(rst_b),
		.en(clk_en),
		.check_on(check_on[0]),
		.fault_clear(1'b0),
		.watched_clk(main_osc_in),
		.fault(fault_now[0]),
		.state(chk_state[0])
	);
	occ_checker u_chk_boot (
		.clk(clk),
		.rst_b(rst_b),
		.en(clk_en),
		.check_on(check_on[1]),
		.fault_clear(1'b0),
		.watched_clk(boot_osc_in),
		.fault(fault_now[1]),
		.state(chk_state[1])
	);
	occ_checker u_chk_pll (
		.clk(clk),
		.rst_b(rst_b),
		.en(clk_en),
		.check_on(check_on[2]),
		.fault_clear(1'b0),
		.watched_clk(pll_clk_in),
		.fault(fault_now[2]),
		.state(chk_state[2])
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_last_q <= 3'h0;
		end else if (clk_en) begin
			fault_last_q <= fault_now;
		end
	end
	assign fault_rise = fault_now & ~fault_last_q;

	// Sticky status: a new fault in the same cycle as the clearing read wins.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= 3'h0;
		end else if (clk_en) begin
			status_q <= (rd_status ? 3'h0 : status_q) | fault_rise;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_q <= 3'h0;
		end else if (clk_en && reg_wr && (reg_addr == `OCC_OFF_FAULT_MASK)) begin
			mask_q <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else if (clk_en) begin
			irq_q <= |(((rd_status ? 3'h0 : status_q) | fault_rise) & mask_q);
		end
	end

	always_comb begin
		cfg_view = 32'h0;
		cfg_view[`OCC_POS_HI_ONES_LO+7:`OCC_POS_HI_ONES_LO] = `OCC_RST_HI_ONES;
		cfg_view[`OCC_POS_PLL_PD] = pll_pd_q;
		cfg_view[`OCC_POS_PLL_OE_N] = pll_oe_n_q;
		cfg_view[`OCC_POS_PLL_CHK] = pll_check_enable_q;
		cfg_view[`OCC_POS_CRYSTAL_CODE_HI:`OCC_POS_CRYSTAL_CODE_LO] = crystal_code_q;
		cfg_view[`OCC_POS_SRC_HI:`OCC_POS_SRC_LO] = src_q;
		cfg_view[`OCC_POS_BOSC_CHK] = boot_osc_check_enable_q;
		cfg_view[`OCC_POS_MOSC_CHK] = main_osc_check_enable_q;
		cfg_view[1:0] = 2'h0;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 32'h0;
		end else if (clk_en) begin
			if (!reg_rd) begin
				rdata_q <= 32'h0;
			end else if (reg_addr == `OCC_OFF_RUN_CFG) begin
				rdata_q <= cfg_view;
			end else if (reg_addr == `OCC_OFF_FAULT_STATUS) begin
				rdata_q <= {29'h0, status_q};
			end else if (reg_addr == `OCC_OFF_FAULT_MASK) begin
				rdata_q <= {29'h0, mask_q};
			end else if (reg_addr == `OCC_OFF_CHECK_STATE) begin
				rdata_q <= {26'h0, chk_state[2], chk_state[1], chk_state[0]};
			end else begin
				rdata_q <= 32'h0;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign crystal_code = crystal_code_q;
	assign osc_leg_source_select = src_q;
	assign pll_power_down = pll_pd_q;
	assign pll_output_enable_n = pll_oe_n_q;
	assign pll_mode = pll_mode_q;
	assign irq = irq_q;
endmodule

/* File: test/occ_top_sva.sv */
// Port-level assertions for the clock check block.
`timescale 1ns/1ns
`include "occ_map.svh"
module occ_top_sva
	import occ_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [`OCC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [3:0] crystal_code,
	input wire occ_src_type osc_leg_source_select,
	input wire logic pll_power_down,
	input wire logic pll_output_enable_n,
	input wire occ_pll_mode_type pll_mode,
	input wire logic irq
);
	logic [31:0] wd_q;
	always_ff @(posedge clk) begin
		wd_q <= reg_wdata;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence cfg_wr;
		clk_en && reg_wr && reg_addr == 8'h60;
	endsequence
	sequence cfg_rd;
		clk_en && reg_rd && reg_addr == 8'h60;
	endsequence
	a_crystal_code_taken: assert property (cfg_wr ##0 reg_wdata[9:6] > 4'h3 |=> crystal_code == wd_q[9:6])
		else $error("crystal code not taken");
	a_crystal_code_reserved: assert property (cfg_wr ##0 reg_wdata[9:6] < 4'h4 |=> $stable(crystal_code))
		else $error("reserved crystal code taken");
	a_src_taken: assert property (cfg_wr |=> osc_leg_source_select == (wd_q[5:4] == 2'b11 ? $past(osc_leg_source_select) : wd_q[5:4]))
		else $error("source select wrong");
	a_pll_bits: assert property (cfg_wr |=> pll_power_down == wd_q[13] && pll_output_enable_n == wd_q[12])
		else $error("pll control bits wrong");
	a_pd_wins: assert property (clk_en && pll_power_down |=> pll_mode == OCC_PLL_POWER_DOWN)
		else $error("power down not applied");
	a_mode_normal: assert property (clk_en && !pll_power_down && !pll_output_enable_n |=> pll_mode == OCC_PLL_NORMAL)
		else $error("normal mode not applied");
	a_cfg_readback: assert property (cfg_rd |=> reg_rdata[21:14] == 8'hff && reg_rdata[1:0] == 2'b00 && reg_rdata[9:6] == crystal_code)
		else $error("config readback wrong");
	// The interrupt register uses the mask of the cycle before, so a mask write
	// one cycle back may still lower it legally.
	a_irq_sticky: assert property (irq && !reg_wr && !$past(reg_wr) && !(clk_en && reg_rd && reg_addr == 8'h70) |=> irq)
		else $error("interrupt dropped early");
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the clock check block.
`timescale 1ns/1ns
module testbench;
	import occ_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic pll_clk_in = 1'b0;
	logic boot_osc_in = 1'b0;
	logic main_osc_in = 1'b0;
	logic [2:0] osc_run = 3'h7;
	logic [3:0] crystal_code;
	occ_src_type osc_leg_source_select;
	logic pll_power_down;
	logic pll_output_enable_n;
	occ_pll_mode_type pll_mode;
	logic irq;
	logic rd_seen = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] cfg;
	logic [31:0] d;
	int seed = 32'h6382;
	int n_mismatch = 0;
	int total_checks = 0;
	occ_top occ_top_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pll_clk_in(pll_clk_in), .boot_osc_in(boot_osc_in), .main_osc_in(main_osc_in),
		.crystal_code(crystal_code), .osc_leg_source_select(osc_leg_source_select),
		.pll_power_down(pll_power_down), .pll_output_enable_n(pll_output_enable_n),
		.pll_mode(pll_mode), .irq(irq));
	initial begin
		forever #20 clk = ~clk;
	end
	// Watched clocks toggle every cycle while running, and sit still when stopped.
	always @(posedge clk) begin
		pll_clk_in <= pll_clk_in ^ osc_run[2];
		boot_osc_in <= boot_osc_in ^ osc_run[1];
		main_osc_in <= main_osc_in ^ osc_run[0];
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	// A quiet cycle follows each access so a strobe is never driven twice in one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		reg_addr <= a;
		reg_wdata <= dat;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(want);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		rd_seen <= reg_rd;
		if (rd_seen) begin
			check(reg_rdata, exp_q.pop_front());
		end
	end
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#160000;
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		cfg = 32'h003ff2c0;
		rd(8'h60, cfg);
		check(pll_mode, OCC_PLL_POWER_DOWN);
		$display("Test reset values done");
		// Every crystal code against every source code; reserved ones must not stick.
		for (int i = 0; i < 64; i++) begin
			// Reserved bits 1:0 are written back as they read, which is zero.
			d = ($random(seed) & 32'h003ff000) | (i << 4);
			wr(8'h60, d);
			if (i[5:2] > 4'h3) cfg[9:6] = i[5:2];
			if (i[1:0] != 2'b11) cfg[5:4] = i[1:0];
			cfg[13:12] = d[13:12];
			rd(8'h60, cfg);
			check(crystal_code, cfg[9:6]);
			check(osc_leg_source_select, cfg[5:4]);
			check(pll_mode, cfg[13] ? 32'h2 : {31'h0, cfg[12]});
		end
		$display("Test field codes done");
		// A write while the clock enable is low must leave every field as it was.
		clk_en <= 1'b0;
		wr(8'h60, 32'h0000040c);
		clk_en <= 1'b1;
		rd(8'h60, cfg);
		$display("Test clock enable freeze done");
		wr(8'h74, 32'h0);
		osc_run <= 3'h4;
		wr(8'h60, 32'h0000040c);
		// Well inside the timeout all three timers must still be running.
		repeat (200) @(posedge clk);
		rd(8'h78, 32'h15);
		repeat (100) @(posedge clk);
		check(irq, 1'b0);
		rd(8'h78, 32'h1a);
		wr(8'h74, 32'h7);
		@(posedge clk);
		check(irq, 1'b1);
		rd(8'h74, 32'h7);
		wr(8'h60, 32'h0);
		rd(8'h70, 32'h3);
		rd(8'h70, 32'h0);
		rd(8'h7c, 32'h0);
		check(irq, 1'b0);
		$display("Test clock faults done");
		summarize();
	end
endmodule
bind occ_top occ_top_sva occ_top_sva_i (.*);
